/* File: common/lcst_defs.svh */
// Constants for the LCD common/segment timing block.
// Assumes inclusion by bare name from package and design files.
`ifndef LCST_DEFS_SVH
`define LCST_DEFS_SVH

// Register word indices; byte address is four times the index
`define LCST_IDX_ENABLE   10'h06a
`define LCST_IDX_SEG_BASE 10'h060
`define LCST_SEG_COUNT    9
`define LCST_SEG_IDX_W    4
`define LCST_SEG_LAST     4'h8

// Enable register layout and reset value
`define LCST_EN_W         4
`define LCST_EN_ON_BIT    3
`define LCST_EN_TONE_BIT  2
`define LCST_EN_DHI_BIT   1
`define LCST_EN_DLO_BIT   0
`define LCST_EN_RESET     4'h0

// Frame timing: 62.5 Hz frame is 16 ms, eight phase slots per frame
`define LCST_FRAME_NS     64'd16000000
`define LCST_CLK_PS       64'd4000
`define LCST_SLOTS        64'd8
`define LCST_CNT_W        20
`define LCST_SLOT_W       3

// Drive level codes on the common outputs
`define LCST_LVL_GND      2'h0
`define LCST_LVL_MID      2'h1
`define LCST_LVL_SUP      2'h2

`endif

/* File: common/lcst_pkg.sv */
// Types shared by the LCD timing block files.
// Assumes lcst_defs.svh is on the include path.
package lcst_pkg;
`include "lcst_defs.svh"
   // Three-level common drive code
   typedef logic [1:0] lcst_level_t;
   // One segment pin's four segment bits, bit k pairs with common k
   typedef logic [3:0] lcst_nib_t;
   // Scan mode of the drive outputs
   typedef enum logic {LCST_BLANK, LCST_SCAN} lcst_mode_t;
endpackage

/* File: src/lcst_seg_latch.sv */
// Segment data latch: nine nibbles, one per segment pin.
// Assumes one write port and one registered read port, same clock.
`timescale 1ns/1ps
`include "lcst_defs.svh"
module lcst_seg_latch (
   // Clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // Write port
   input  wire logic                          wr_en,
   input  wire logic [`LCST_SEG_IDX_W-1:0]    wr_idx,
   input  wire lcst_pkg::lcst_nib_t           wr_data,
   // Read port, data one cycle after the index
   input  wire logic [`LCST_SEG_IDX_W-1:0]    rd_idx,
   output lcst_pkg::lcst_nib_t                rd_data_q,
   // All nibbles at once for the waveform generator
   output logic [`LCST_SEG_COUNT*4-1:0]       all_q
);
   import lcst_pkg::*;

   lcst_nib_t mem_q [`LCST_SEG_COUNT];

   // One latch entry per segment pin
   genvar g;
   generate
      for (g = 0; g < `LCST_SEG_COUNT; g++) begin : g_ent
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_q[g] <= 4'h0;
            end else if (wr_en && wr_idx == `LCST_SEG_IDX_W'(g)) begin
               mem_q[g] <= wr_data;
            end
         end
         assign all_q[g*4 +: 4] = mem_q[g];
      end
   endgenerate

   // Registered read; out-of-range index reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data_q <= 4'h0;
      end else begin
         rd_data_q <= (rd_idx <= `LCST_SEG_LAST) ? mem_q[rd_idx] : 4'h0;
      end
   end
endmodule

/* File: src/lcst_top.sv */
// LCD common and segment drive timing with an APB register slave.
// Assumes an APB master on pclk and a passive 4-common glass panel.
`timescale 1ns/1ps
`include "lcst_defs.svh"
module lcst_top #(
   parameter int unsigned SLOT_CYCLES =
      int'(`LCST_FRAME_NS * 64'd1000 / `LCST_CLK_PS / `LCST_SLOTS)
) (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic [31:0]                     prdata_q,
   output logic                            pready_q,
   output logic                            pslverr_q,
   // Common drive level codes
   output lcst_pkg::lcst_level_t           common_drive_0_q,
   output lcst_pkg::lcst_level_t           common_drive_1_q,
   output lcst_pkg::lcst_level_t           common_drive_2_q,
   output lcst_pkg::lcst_level_t           common_drive_3_q,
   // Segment drives, 0 ground, 1 supply
   output logic [`LCST_SEG_COUNT-1:0]      segment_drive_q,
   // Enable register side bits
   output logic                            tone_output_select_q,
   output logic                            port_group_dir_hi_q,
   output logic                            port_group_dir_lo_q
);
   import lcst_pkg::*;

   logic [`LCST_EN_W-1:0]           en_q;
   logic [`LCST_CNT_W-1:0]          slot_cnt_q;
   logic [`LCST_SLOT_W-1:0]         slot_q;
   logic [`LCST_SEG_COUNT*4-1:0]    seg_all;
   lcst_nib_t                       seg_rd;
   lcst_level_t                     com_d [4];
   logic [`LCST_SEG_COUNT-1:0]      seg_d;
   lcst_mode_t                      mode;

   // Address decode; only word-aligned addresses map
   wire [9:0] idx      = paddr[11:2];
   wire       aligned  = (paddr[1:0] == 2'h0);
   wire       hit_en   = aligned && (idx == `LCST_IDX_ENABLE);
   wire [9:0] seg_off  = idx - `LCST_IDX_SEG_BASE;
   wire       hit_seg  = aligned && (idx >= `LCST_IDX_SEG_BASE) &&
                         (seg_off < 10'(`LCST_SEG_COUNT));
   wire       mapped   = hit_en || hit_seg;
   wire       acc_done = psel && penable && pready_q;
   wire       acc_wr   = acc_done && pwrite && pstrb[0];
   wire       wr_en    = acc_wr && hit_en;
   wire       wr_seg   = acc_wr && hit_seg;
   wire       ans_now  = psel && penable && !pready_q;

   // Read data selection, enable bits sit in the low nibble
   wire [31:0] rd_mux = hit_en  ? {28'h0, en_q} :
                        hit_seg ? {28'h0, seg_rd} : 32'h0;

   // Segment data latch with registered read
   lcst_seg_latch u_latch (
      .pclk      (pclk),
      .presetn   (presetn),
      .wr_en     (wr_seg),
      .wr_idx    (seg_off[`LCST_SEG_IDX_W-1:0]),
      .wr_data   (pwdata[3:0]),
      .rd_idx    (seg_off[`LCST_SEG_IDX_W-1:0]),
      .rd_data_q (seg_rd),
      .all_q     (seg_all)
   );

   // APB answer: one wait state so the latch read can settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= ans_now;
         pslverr_q <= ans_now && !mapped;
         prdata_q  <= ans_now ? rd_mux : 32'h0;
      end
   end

   // Enable register; the async reset clears it, a write with pstrb[0] set loads it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= `LCST_EN_RESET;
      end else if (wr_en) begin
         en_q <= pwdata[`LCST_EN_W-1:0];
      end
   end

   assign tone_output_select_q = en_q[`LCST_EN_TONE_BIT];
   assign port_group_dir_hi_q  = en_q[`LCST_EN_DHI_BIT];
   assign port_group_dir_lo_q  = en_q[`LCST_EN_DLO_BIT];
   assign mode = en_q[`LCST_EN_ON_BIT] ? LCST_SCAN : LCST_BLANK;

   // Free-running slot divider; nothing but reset stops it, so a
   // halted core never freezes the glass at a DC level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_cnt_q <= '0;
         slot_q     <= '0;
      end else if (slot_cnt_q == `LCST_CNT_W'(SLOT_CYCLES - 1)) begin
         slot_cnt_q <= '0;
         slot_q     <= slot_q + 3'h1;
      end else begin
         slot_cnt_q <= slot_cnt_q + `LCST_CNT_W'(1);
      end
   end

   // Common k is selected in slot k at supply and slot k+4 at ground
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_com
         assign com_d[k] =
            (mode == LCST_BLANK)      ? `LCST_LVL_GND :
            (slot_q[1:0] != 2'(k))    ? `LCST_LVL_MID :
            slot_q[2]                 ? `LCST_LVL_GND : `LCST_LVL_SUP;
      end
   endgenerate

   // Segment opposes the selected common when lit, follows it if not
   genvar g;
   generate
      for (g = 0; g < `LCST_SEG_COUNT; g++) begin : g_seg
         wire lit = seg_all[g*4 + int'(slot_q[1:0])];
         assign seg_d[g] = (mode == LCST_BLANK) ? 1'b0 :
                           (lit ? slot_q[2] : !slot_q[2]);
      end
   endgenerate

   // Registered pins, low in reset and while the display is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         common_drive_0_q <= `LCST_LVL_GND;
         common_drive_1_q <= `LCST_LVL_GND;
         common_drive_2_q <= `LCST_LVL_GND;
         common_drive_3_q <= `LCST_LVL_GND;
         segment_drive_q  <= '0;
      end else begin
         common_drive_0_q <= com_d[0];
         common_drive_1_q <= com_d[1];
         common_drive_2_q <= com_d[2];
         common_drive_3_q <= com_d[3];
         segment_drive_q  <= seg_d;
      end
   end

   // Checks on the drive timing and the register file
   wire [3:0] com_sel = {common_drive_3_q != `LCST_LVL_MID,
                         common_drive_2_q != `LCST_LVL_MID,
                         common_drive_1_q != `LCST_LVL_MID,
                         common_drive_0_q != `LCST_LVL_MID};

   blank_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en_q[`LCST_EN_ON_BIT] |=> segment_drive_q == '0 &&
      common_drive_0_q == `LCST_LVL_GND &&
      common_drive_1_q == `LCST_LVL_GND &&
      common_drive_2_q == `LCST_LVL_GND &&
      common_drive_3_q == `LCST_LVL_GND)
      else $error("pins not blanked with display off");

   one_common_a: assert property (@(posedge pclk) disable iff (!presetn)
      en_q[`LCST_EN_ON_BIT] |=> $onehot(com_sel))
      else $error("not exactly one common selected while on");

   enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en |=> en_q == $past(pwdata[3:0]))
      else $error("enable register write lost");

   slot_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      slot_cnt_q == `LCST_CNT_W'(SLOT_CYCLES - 1) |=>
      slot_q == $past(slot_q) + 3'h1 && slot_cnt_q == '0)
      else $error("slot did not advance at divider wrap");

   divider_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      slot_cnt_q <= `LCST_CNT_W'(SLOT_CYCLES - 1))
      else $error("slot divider out of range");

   common_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
      en_q[`LCST_EN_ON_BIT] && slot_q == 3'h4 |=>
      common_drive_0_q == `LCST_LVL_GND)
      else $error("common 0 not at ground in its second slot");

   seg_pattern_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(en_q[`LCST_EN_ON_BIT]) && common_drive_0_q == `LCST_LVL_SUP |->
      segment_drive_q[0] == !$past(seg_all[0]))
      else $error("segment 0 wrong against common 0");

   reset_low_a: assert property (@(posedge pclk)
      !presetn |-> en_q == `LCST_EN_RESET && segment_drive_q == '0)
      else $error("reset did not clear display");

   free_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(en_q) |-> $past(slot_cnt_q) != slot_cnt_q)
      else $error("divider stalled by register write");

   cov_on_c:   cover property (@(posedge pclk) disable iff (!presetn)
      $rose(en_q[`LCST_EN_ON_BIT]));
   cov_wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
      en_q[`LCST_EN_ON_BIT] && slot_q == 3'h7 ##1 slot_q == 3'h0);
   cov_err_c:  cover property (@(posedge pclk) disable iff (!presetn)
      pready_q && pslverr_q);
endmodule

/* File: test/lcst_glass_model.sv */
// Passive four-common glass: flags each segment whose cell sees full supply.
// Assumes level codes from the drive block, segment pins 0 ground 1 supply.
`timescale 1ns/1ps
`include "lcst_defs.svh"
module lcst_glass_model (
   // Common drive levels
   input  wire lcst_pkg::lcst_level_t com_0,
   input  wire lcst_pkg::lcst_level_t com_1,
   input  wire lcst_pkg::lcst_level_t com_2,
   input  wire lcst_pkg::lcst_level_t com_3,
   // Segment pin levels
   input  wire logic [8:0]            seg,
   // Lit cells, bit g*4+k is segment pin g against common k
   output logic [35:0]                lit
);
   import lcst_pkg::*;
   lcst_level_t com [4];
   assign com = '{com_0, com_1, com_2, com_3};
   // Cell lit only across full supply; half bias never lights
   always_comb begin
      for (int g = 0; g < 9; g++) begin
         for (int k = 0; k < 4; k++) begin
            lit[g*4+k] = (com[k] == `LCST_LVL_SUP && !seg[g]) ||
                         (com[k] == `LCST_LVL_GND && seg[g]);
         end
      end
   end
endmodule

/* File: test/tb.sv */
// Bench for the LCD drive timing block: APB tasks and scan checks.
// Assumes lcst_top, the glass model and the package are compiled first.
`timescale 1ns/1ps
`include "lcst_defs.svh"
module tb;
   import lcst_pkg::*;
   localparam int unsigned SLOT = 8;
   localparam logic [11:0] EN_A = 12'h1a8;
   localparam logic [11:0] SEG_A = 12'h180;
   logic        pclk = 1'b0;
   logic        presetn = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = '0;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   lcst_level_t c0, c1, c2, c3;
   logic [8:0]  seg_q;
   wire  [2:0]  side;
   logic [35:0] lit;
   logic [31:0] rd;
   logic        err;
   lcst_nib_t   nib [9];
   int          mismatches = 0;
   int          checks_done = 0;
   wire  [7:0]  coms = {c3, c2, c1, c0};

   lcst_top #(.SLOT_CYCLES(SLOT)) lcst_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .common_drive_0_q(c0), .common_drive_1_q(c1),
      .common_drive_2_q(c2), .common_drive_3_q(c3),
      .segment_drive_q(seg_q), .tone_output_select_q(side[2]),
      .port_group_dir_hi_q(side[1]), .port_group_dir_lo_q(side[0]));
   lcst_glass_model lcst_glass_model_i (
      .com_0(c0), .com_1(c1), .com_2(c2), .com_3(c3), .seg(seg_q),
      .lit(lit));

   // 250 MHz clock
   always #2 pclk = ~pclk;

   task check(input string name, input logic [35:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; entry waits an edge so psel is never set twice
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait that never gets an answer
      while (pready_q !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata_q;
      err = pslverr_q;
      check("wait_states", n, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Slot phase is free running, so lock on a change then sample mid-slot
   task scan;
      int s, prev, n;
      logic [7:0] c_old, ec;
      logic [8:0] es;
      logic [35:0] el;
      c_old = coms;
      n = 0;
      prev = -1;
      while (coms === c_old && n < 3*SLOT) begin
         @(posedge pclk);
         n++;
      end
      check("slot_change", 36'(n < 3*SLOT), 1);
      repeat (SLOT/2) @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
         s = -1;
         el = '0;
         for (int k = 0; k < 4; k++)
            if (coms[2*k+:2] !== `LCST_LVL_MID)
               s = k + ((coms[2*k+:2] === `LCST_LVL_GND) ? 4 : 0);
         if (s < 0) begin
            check("active_common", 0, 1);
            s = 0;
         end
         if (prev >= 0) check("slot", 36'(s), 36'((prev + 1) % 8));
         ec = 8'h55;
         ec[2*(s%4)+:2] = (s < 4) ? `LCST_LVL_SUP : `LCST_LVL_GND;
         for (int g = 0; g < 9; g++) begin
            es[g] = nib[g][s%4] ? s[2] : ~s[2];
            el[g*4+s%4] = nib[g][s%4];
         end
         check("commons", coms, ec);
         check("segments", seg_q, es);
         check("glass", lit, el);
         prev = s;
         repeat (SLOT) @(posedge pclk);
      end
   endtask

   task print_verdict;
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #40000;
      mismatches++;
      print_verdict;
   end

   // Falling edge at time zero puts every flop in reset before any clock
   initial begin
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset_pins", {coms, seg_q, side}, 0);
      apb(1'b0, EN_A, 0, 4'h0);
      check("en_reset", rd, 0);
      for (int p = 0; p < 2; p++) begin
         for (int g = 0; g < 9; g++) begin
            nib[g] = 4'(g + 7*p);
            apb(1'b1, SEG_A + 12'(4*g), 32'(nib[g]), 4'hf);
         end
         apb(1'b0, SEG_A + 12'h20, 0, 4'h0);
         check("seg_rw", rd, 32'(nib[8]));
         apb(1'b1, EN_A, 32'hffff_fff9, 4'hf);
         apb(1'b1, EN_A, 32'h6, 4'h0);
         apb(1'b0, EN_A, 0, 4'h0);
         check("en_rw", rd, 9);
         check("side_bits", side, 3'b001);
         scan;
         apb(1'b0, EN_A, 0, 4'h0);
         check("en_held", rd, 9);
      end
      apb(1'b0, 12'hffc, 0, 4'h0);
      check("unmapped", {err, rd}, {1'b1, 32'h0});
      apb(1'b0, EN_A + 12'h1, 0, 4'h0);
      check("unaligned", err, 1);
      apb(1'b1, EN_A, 32'h7, 4'hf);
      repeat (2) @(posedge pclk);
      check("blank_pins", {coms, seg_q}, 0);
      check("blank_glass", lit, 0);
      check("side_kept", side, 3'b111);
      repeat (3*SLOT) @(posedge pclk);
      check("blank_stays", {coms, seg_q}, 0);
      apb(1'b1, EN_A, 32'hf, 4'hf);
      repeat (SLOT) @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      check("rst_pins", {coms, seg_q, side}, 0);
      presetn <= 1'b1;
      apb(1'b0, EN_A, 0, 4'h0);
      check("rst_en", rd, 0);
      print_verdict;
   end
endmodule
